// *** design/occ_consts.svh ***
// offsets, alias codes, field positions, write mask and reset values for the compare channel
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH
`define OCC_CTRL_OFS 8'h00
`define OCC_PRI_OFS 8'h10
`define OCC_SEC_OFS 8'h20
`define OCC_STAT_OFS 8'h30
`define OCC_ALIAS_CLR 2'h1
`define OCC_ALIAS_SET 2'h2
`define OCC_ALIAS_INV 2'h3
`define OCC_BIT_ON 15
`define OCC_BIT_IDLE 13
`define OCC_BIT_WIDE 5
`define OCC_BIT_FAULT 4
`define OCC_BIT_TSEL 3
`define OCC_CTRL_WMASK 32'h0000_A02F
`define OCC_CTRL_RESET 32'h0000_0000
`define OCC_CMP_RESET 32'h0000_0000
`define OCC_UNMAPPED_DATA 32'h0000_0000
`endif

// *** design/occ_pkg.sv ***
// types shared by the output compare channel
package occ_pkg;
    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'b000,
        OCC_MODE_HIGH = 3'b001,
        OCC_MODE_LOW = 3'b010,
        OCC_MODE_TOGGLE = 3'b011,
        OCC_MODE_PULSE = 3'b100,
        OCC_MODE_TRAIN = 3'b101,
        OCC_MODE_PWM = 3'b110,
        OCC_MODE_PWM_FLT = 3'b111
    } occ_mode_e;

    // avalon-mm slave request
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } occ_avm_req_s;

    // avalon-mm slave answer
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid;
    } occ_avm_rsp_s;

    // control register fields held by hardware
    typedef struct packed {
        logic on;
        logic idle_halt_select;
        logic wide_compare_select;
        logic fault_status_flag;
        logic time_base_select;
        occ_mode_e mode_field;
    } occ_ctrl_s;
endpackage

// *** design/occ_channel.sv ***
// output compare channel with avalon-mm register slave
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "occ_consts.svh"

module occ_channel (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire occ_pkg::occ_avm_req_s i_avm,
    output occ_pkg::occ_avm_rsp_s o_avm,
    input wire logic [31:0] i_first_timer,
    input wire logic [31:0] i_second_timer,
    input wire logic i_timer_reload,
    input wire logic i_cpu_idle,
    input wire logic i_fault_n,
    output logic o_compare_output_pin,
    output logic o_channel_interrupt_flag,
    output logic o_channel_active
);
    import occ_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] idle_sync_r;
    logic [1:0] fault_sync_r;
    logic [1:0] idle_sync_nxt;
    logic [1:0] fault_sync_nxt;

    always_comb begin
        idle_sync_nxt = {idle_sync_r[0], i_cpu_idle};
        fault_sync_nxt = {fault_sync_r[0], ~i_fault_n};
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            idle_sync_r <= 2'h0;
            fault_sync_r <= 2'h0;
        end else begin
            idle_sync_r <= idle_sync_nxt;
            fault_sync_r <= fault_sync_nxt;
        end
    end

    wire logic idle_s = idle_sync_r[1];
    wire logic fault_s = fault_sync_r[1];

    // ****************************************
    // register slave
    // ****************************************
    occ_ctrl_s ctrl_r;
    occ_ctrl_s ctrl_nxt;
    logic [31:0] pri_r;
    logic [31:0] pri_nxt;
    logic [31:0] sec_r;
    logic [31:0] sec_nxt;
    occ_avm_rsp_s rsp_r;
    occ_avm_rsp_s rsp_nxt;
    logic fault_set;
    logic fault_clr;

    // one wait cycle, then the access completes; registers stay
    // reachable whether or not the channel is switched on
    logic busy;
    logic [1:0] alias_sel;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [31:0] be_mask;

    // ****************************************
    // access phases
    // ****************************************
    // read data are fetched while waitrequest is still high, so that
    // they stand from a flop at the edge where waitrequest is low
    logic rd_fetch;
    logic wr_phase;

    always_comb begin
        rd_fetch = i_avm.read & ~rsp_r.waitrequest;
        wr_phase = i_avm.write & rsp_r.waitrequest;
    end

    function automatic logic [31:0] occ_apply(
        input logic [31:0] cur,
        input logic [31:0] wd,
        input logic [31:0] msk,
        input logic [1:0] sel
    );
        logic [31:0] res;
        res = cur;
        unique case (sel)
            2'h0: res = (cur & ~msk) | (wd & msk);
            `OCC_ALIAS_CLR: res = cur & ~(wd & msk);
            `OCC_ALIAS_SET: res = cur | (wd & msk);
            `OCC_ALIAS_INV: res = cur ^ (wd & msk);
        endcase
        return res;
    endfunction

    always_comb begin
        busy = i_avm.read | i_avm.write;
        alias_sel = i_avm.address[3:2];
        be_mask = {
            {8{i_avm.byteenable[3]}},
            {8{i_avm.byteenable[2]}},
            {8{i_avm.byteenable[1]}},
            {8{i_avm.byteenable[0]}}
        };
        ctrl_word = 32'h0000_0000;
        ctrl_word[`OCC_BIT_ON] = ctrl_r.on;
        ctrl_word[`OCC_BIT_IDLE] = ctrl_r.idle_halt_select;
        ctrl_word[`OCC_BIT_WIDE] = ctrl_r.wide_compare_select;
        ctrl_word[`OCC_BIT_TSEL] = ctrl_r.time_base_select;
        ctrl_word[2:0] = ctrl_r.mode_field;
        // fault flag is not software writable
        wmask = be_mask & `OCC_CTRL_WMASK;
        ctrl_new = occ_apply(ctrl_word, i_avm.writedata, wmask, alias_sel);
        ctrl_nxt = ctrl_r;
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        rsp_nxt = '0;
        rsp_nxt.waitrequest = busy;
        if (busy && rsp_r.waitrequest) begin
            rsp_nxt.waitrequest = 1'b0;
            if (wr_phase) begin
                unique case ({i_avm.address[7:4], 4'h0})
                    `OCC_CTRL_OFS: begin
                        // each bit updates only from its own lane
                        ctrl_nxt.on = ctrl_new[`OCC_BIT_ON];
                        ctrl_nxt.idle_halt_select = ctrl_new[`OCC_BIT_IDLE];
                        ctrl_nxt.wide_compare_select =
                            ctrl_new[`OCC_BIT_WIDE];
                        ctrl_nxt.time_base_select = ctrl_new[`OCC_BIT_TSEL];
                        ctrl_nxt.mode_field = occ_mode_e'(ctrl_new[2:0]);
                    end
                    `OCC_PRI_OFS: pri_nxt = occ_apply(pri_r,
                        i_avm.writedata, be_mask, alias_sel);
                    `OCC_SEC_OFS: sec_nxt = occ_apply(sec_r,
                        i_avm.writedata, be_mask, alias_sel);
                    default: ;
                endcase
            end
        end

        // alias reads carry no meaning and return zero
        if (rd_fetch && alias_sel == 2'h0) begin
            unique case ({i_avm.address[7:4], 4'h0})
                `OCC_CTRL_OFS: begin
                    rsp_nxt.readdata = ctrl_word;
                    rsp_nxt.readdata[`OCC_BIT_FAULT] =
                        ctrl_r.fault_status_flag &
                        (ctrl_r.mode_field == OCC_MODE_PWM_FLT);
                end
                `OCC_PRI_OFS: rsp_nxt.readdata = pri_r;
                `OCC_SEC_OFS: rsp_nxt.readdata = sec_r;
                default: rsp_nxt.readdata = `OCC_UNMAPPED_DATA;
            endcase
        end

        // hardware set wins over hardware clear
        if (fault_clr) begin
            ctrl_nxt.fault_status_flag = 1'b0;
        end
        if (fault_set) begin
            ctrl_nxt.fault_status_flag = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r <= occ_ctrl_s'(8'h00);
            pri_r <= `OCC_CMP_RESET;
            sec_r <= `OCC_CMP_RESET;
            rsp_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pri_r <= pri_nxt;
            sec_r <= sec_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // waitrequest must be high in the cycle a request appears, so it is
    // combined with the registered ack phase rather than a bare flop
    always_comb begin
        o_avm = rsp_r;
        o_avm.waitrequest = busy & ~rsp_r.waitrequest;
    end

    // ****************************************
    // compare engine
    // ****************************************
    logic pin_r;
    logic pin_nxt;
    logic irq_r;
    logic irq_nxt;
    logic done_r;
    logic done_nxt;
    logic act_r;
    logic act_nxt;
    logic [2:0] mode_q_r;
    logic [2:0] mode_q_nxt;
    logic run;
    logic [31:0] count;
    logic hit_pri;
    logic hit_sec;
    logic pwm;

    // ****************************************
    // match detection
    // ****************************************
    // a narrow compare masks the upper half of both sides, so upper
    // bits left over in the compare registers never block a match
    always_comb begin
        run = ctrl_r.on & ~(ctrl_r.idle_halt_select & idle_s);

        count = ctrl_r.time_base_select ? i_second_timer
                                        : i_first_timer;

        if (ctrl_r.wide_compare_select) begin
            hit_pri = count == pri_r;
            hit_sec = count == sec_r;
        end else begin
            hit_pri = count[15:0] == pri_r[15:0];
            hit_sec = count[15:0] == sec_r[15:0];
        end

        pwm = ctrl_r.mode_field[2] & ctrl_r.mode_field[1];
    end

    // ****************************************
    // mode engine
    // ****************************************
    always_comb begin
        pin_nxt = pin_r;
        irq_nxt = 1'b0;
        done_nxt = done_r;
        act_nxt = act_r;
        mode_q_nxt = ctrl_r.mode_field;
        fault_set = 1'b0;
        fault_clr = 1'b0;
        if (!ctrl_r.on || mode_q_r != ctrl_r.mode_field) begin
            // (re)entering a mode sets the initial pin level
            done_nxt = 1'b0;
            act_nxt = 1'b0;
            pin_nxt = ctrl_r.mode_field == OCC_MODE_LOW;
            fault_clr = ctrl_r.mode_field != OCC_MODE_PWM_FLT;
        end else if (run) begin
            unique case (ctrl_r.mode_field)
                OCC_MODE_OFF: ;
                OCC_MODE_HIGH: if (hit_pri && !done_r) begin
                    pin_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    done_nxt = 1'b1;
                end
                OCC_MODE_LOW: if (hit_pri && !done_r) begin
                    pin_nxt = 1'b0;
                    irq_nxt = 1'b1;
                    done_nxt = 1'b1;
                end
                OCC_MODE_TOGGLE: if (hit_pri) begin
                    pin_nxt = ~pin_r;
                    irq_nxt = 1'b1;
                end
                OCC_MODE_PULSE, OCC_MODE_TRAIN: begin
                    if (hit_pri && !done_r && !pin_r) begin
                        pin_nxt = 1'b1;
                    end else if (hit_sec && pin_r) begin
                        pin_nxt = 1'b0;
                        irq_nxt = 1'b1;
                        done_nxt = ~ctrl_r.mode_field[0];
                    end
                end
                default: begin
                    if (i_timer_reload) begin
                        // pin goes high at each period start unless secondary is zero or a fault holds it low; duty compares live against secondary
                        act_nxt = 1'b1;
                        pin_nxt = sec_r != 32'h0000_0000;
                    end else if (hit_sec && act_r) begin
                        pin_nxt = 1'b0;
                    end
                    if (ctrl_r.mode_field[0] && fault_s) begin
                        pin_nxt = 1'b0;
                        fault_set = 1'b1;
                    end else if (ctrl_r.mode_field[0] &&
                                 ctrl_r.fault_status_flag) begin
                        pin_nxt = 1'b0;
                        // fault cleared by hardware at the first period reload after the pin releases
                        fault_clr = i_timer_reload;
                    end
                    irq_nxt = pwm & i_timer_reload;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_r <= 1'b0;
            irq_r <= 1'b0;
            done_r <= 1'b0;
            act_r <= 1'b0;
            mode_q_r <= 3'h0;
        end else begin
            pin_r <= pin_nxt;
            irq_r <= irq_nxt;
            done_r <= done_nxt;
            act_r <= act_nxt;
            mode_q_r <= mode_q_nxt;
        end
    end

    assign o_compare_output_pin = pin_r;
    assign o_channel_interrupt_flag = irq_r;
    assign o_channel_active = act_r;
endmodule

// *** tb/occ_timer_model.sv ***
// time base partner: two timer counts and a period reload pulse
`timescale 1ns/1ps
module occ_timer_model #(
    parameter int PERIOD = 64
) (
    input wire logic i_clk,
    input wire logic i_reset,
    output logic [31:0] o_first,
    output logic [31:0] o_second,
    output logic o_reload
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    always_comb begin
        cnt_nxt = (cnt_r == PERIOD - 1) ? 32'h0 : cnt_r + 32'h1;
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) cnt_r <= 32'h0;
        else cnt_r <= cnt_nxt;
    end
    assign o_first = cnt_r;
    // bit 16 of the upper half set so a narrow compare must mask it away
    assign o_second = cnt_r + 32'h0001_0000;
    assign o_reload = (cnt_r == 32'h0);
endmodule

// *** tb/occ_monitor.sv ***
// concurrent checks on the compare channel ports
`timescale 1ns/1ps
module occ_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire occ_pkg::occ_avm_req_s i_avm,
    input wire occ_pkg::occ_avm_rsp_s o_avm,
    input wire logic i_fault_n,
    input wire logic o_compare_output_pin,
    input wire logic o_channel_interrupt_flag
);
    import occ_pkg::*;
    // ****************************************
    // control shadow, full-lane writes only
    // ****************************************
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic [15:0] wd;
    assign wd = i_avm.writedata[15:0];
    always_comb begin
        sh_nxt = sh_r;
        if (i_avm.write && !o_avm.waitrequest &&
            i_avm.address[7:4] == 4'h0) begin
            case (i_avm.address[3:2])
                2'h0: sh_nxt = wd;
                2'h1: sh_nxt = sh_r & ~wd;
                2'h2: sh_nxt = sh_r | wd;
                default: sh_nxt = sh_r ^ wd;
            endcase
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) sh_r <= 16'h0000;
        else sh_r <= sh_nxt;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence rd_ctrl;
        i_avm.read && !o_avm.waitrequest && i_avm.address == 8'h00;
    endsequence
    sequence rd_alias;
        i_avm.read && !o_avm.waitrequest && i_avm.address[3:2] != 2'h0;
    endsequence
    sequence fault_run;
        (sh_r[2:0] == 3'h7 && !i_fault_n)[*3];
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_alias_read_zero: assert property (
        rd_alias |-> o_avm.readdata == 32'h0)
        else $error("alias read not zero");
    a_ctrl_unimpl_zero: assert property (
        rd_ctrl |-> (o_avm.readdata & 32'hFFFF_5FC0) == 32'h0)
        else $error("unimplemented control bits read set");
    a_flag_mode_only: assert property (
        rd_ctrl ##0 (o_avm.readdata[2:0] != 3'h7) |-> !o_avm.readdata[4])
        else $error("fault flag set outside fault pwm mode");
    a_reset_quiet: assert property (
        $fell(i_reset) |-> !o_compare_output_pin && !o_channel_interrupt_flag)
        else $error("pin or flag set after reset");
    a_irq_one_cycle: assert property (
        o_channel_interrupt_flag |=> !o_channel_interrupt_flag)
        else $error("interrupt flag longer than one cycle");
    a_irq_moves_pin: assert property (
        sh_r[2:0] inside {3'h1, 3'h2, 3'h3} && o_channel_interrupt_flag
        |-> o_compare_output_pin != $past(o_compare_output_pin))
        else $error("single mode flag without pin change");
    a_fault_pin_low: assert property (
        fault_run |=> !o_compare_output_pin)
        else $error("pin driven during fault");
    a_off_no_irq: assert property (
        (!sh_r[15])[*2] |-> !o_channel_interrupt_flag)
        else $error("flag while channel off");
    a_mode_off_quiet: assert property (
        (sh_r[2:0] == 3'h0)[*2] |-> !o_channel_interrupt_flag)
        else $error("flag in mode off");
endmodule

// *** tb/test_occ_channel.sv ***
// self-checking bench for the output compare channel
`timescale 1ns/1ps
module test_occ_channel;
    import occ_pkg::*;
    logic i_clk, i_reset, idle, fault_n, reload, pin, irq, act;
    logic [31:0] t1, t2, q;
    occ_avm_req_s req;
    occ_avm_rsp_s rsp;
    int num_errors, num_checks;
    bit got;
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    occ_channel DUT (.i_clk(i_clk), .i_reset(i_reset), .i_avm(req),
        .o_avm(rsp), .i_first_timer(t1), .i_second_timer(t2),
        .i_timer_reload(reload), .i_cpu_idle(idle), .i_fault_n(fault_n),
        .o_compare_output_pin(pin), .o_channel_interrupt_flag(irq),
        .o_channel_active(act));
    occ_timer_model #(.PERIOD(64)) u_tmr (.i_clk(i_clk),
        .i_reset(i_reset), .o_first(t1), .o_second(t2), .o_reload(reload));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        req <= '{a, !w, w, d, 4'hF};
        do begin
            @(posedge i_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 20);
        q = rsp.readdata;
        req <= '0;
        if (n >= 20) chk(32'h1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic wait_irq(input int n);
        got = 0;
        repeat (n) begin
            @(negedge i_clk);
            if (irq === 1'b1) begin
                got = 1;
                break;
            end
        end
    endtask
    task automatic wait_pin(input int n);
        repeat (n) begin
            @(negedge i_clk);
            if (pin === 1'b1) break;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            bus(8'(i * 16), 1'b0, 32'h0);
            chk(q, 32'h0);
        end
        wr(8'h10, 32'h1234_5678);
        wr(8'h14, 32'h0000_00F0);
        wr(8'h18, 32'h0F00_0000);
        bus(8'h10, 1'b0, 32'h0);
        chk(q, 32'h1F34_5608);
        wr(8'h1C, 32'hFFFF_0000);
        bus(8'h10, 1'b0, 32'h0);
        chk(q, 32'hE0CB_5608);
        bus(8'h30, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(8'h14, 1'b0, 32'h0);
        chk(q, 32'h0);
        wr(8'h00, 32'hFFFF_FFFF);
        bus(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0000_A02F);
        wr(8'h04, 32'h0000_8000);
        bus(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0000_202F);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_single(input logic [31:0] c, input logic [31:0] cmp,
                            input logic init);
        wr(8'h10, cmp);
        wr(8'h00, c);
        repeat (2) @(negedge i_clk);
        chk(pin, init);
        wait_irq(200);
        chk(got, 1'b1);
        chk(pin, !init);
        chk(((c[3] ? t2 : t1) - 32'h1) & (c[5] ? 32'hFFFF_FFFF
            : 32'h0000_FFFF), cmp);
        if (c[2:0] == 3'h3) begin
            wait_irq(200);
            chk(pin, init);
        end
        wr(8'h00, 32'h0);
    endtask
    task automatic t_dual(input logic [31:0] c);
        wr(8'h10, 32'h10);
        wr(8'h20, 32'h30);
        wr(8'h00, c);
        wait_pin(200);
        chk(pin, 1'b1);
        wait_irq(200);
        chk(pin, 1'b0);
        wait_irq(140);
        chk(got, c[0]);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_pwm();
        int hi;
        hi = 0;
        wr(8'h20, 32'h20);
        @(posedge i_clk) fault_n <= 1'b0;
        wr(8'h00, 32'h0000_8006);
        wait_pin(200);
        chk(pin, 1'b1);
        chk(act, 1'b1);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h0000_8007);
        repeat (150) begin
            @(negedge i_clk);
            hi += pin;
        end
        chk(hi, 0);
        bus(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0000_8017);
        wr(8'h04, 32'h0000_0010);
        bus(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0000_8017);
        @(posedge i_clk) fault_n <= 1'b1;
        wr(8'h00, 32'h0);
        bus(8'h00, 1'b0, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_gate();
        wr(8'h10, 32'h20);
        wr(8'h00, 32'h0000_0003);
        wait_irq(140);
        chk(got, 1'b0);
        wr(8'h00, 32'h0000_8000);
        wait_irq(140);
        chk(got, 1'b0);
        wr(8'h00, 32'h0);
        @(posedge i_clk) idle <= 1'b1;
        wr(8'h00, 32'h0000_A003);
        wait_irq(140);
        chk(got, 1'b0);
        @(posedge i_clk) idle <= 1'b0;
        wait_irq(200);
        chk(got, 1'b1);
        wr(8'h00, 32'h0);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        req = '0;
        i_reset = 1'b1;
        idle = 1'b0;
        fault_n = 1'b1;
        num_errors = 0;
        num_checks = 0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_single(32'h0000_8001, 32'h0000_0020, 1'b0);
        t_single(32'h0000_8002, 32'h0000_0030, 1'b1);
        t_single(32'h0000_802B, 32'h0001_0025, 1'b0);
        t_single(32'h0000_8009, 32'h0000_0028, 1'b0);
        t_dual(32'h0000_8004);
        t_dual(32'h0000_8005);
        t_pwm();
        t_gate();
        finish_test();
    end
    // a full run takes far less than this span of cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        finish_test();
    end
endmodule
bind occ_channel occ_monitor u_mon (.i_clk, .i_reset, .i_avm, .o_avm,
    .i_fault_n, .o_compare_output_pin, .o_channel_interrupt_flag);
